// >>> cpu_bus_end.sv
`timescale 1ns/10ps
module cpu_bus_end (
   input wire logic clk,
   input wire logic reset,
   dram_bus_if.cpu bus,
   input wire logic fetch_req,
   input wire logic [15:0] fetch_address,
   input wire logic stall,
   output logic fetch_done,
   output logic [7:0] fetch_data
);
   dram_glue_pkg::cpu_state_type state_reg;
   dram_glue_pkg::cpu_state_type state_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic [6:0] refresh_row_reg;
   logic [6:0] refresh_row_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic [7:0] data_reg;
   logic [7:0] data_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      refresh_row_next = refresh_row_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      fetch_done = 1'b0;
      case (state_reg)
         dram_glue_pkg::CPU_IDLE: begin
            // Stalls must end within 1ms to keep refresh going
            if (stall || bus.cpu_reset) begin
               state_next = dram_glue_pkg::CPU_HALT;
            end else if (fetch_req) begin
               addr_next = fetch_address;
               state_next = dram_glue_pkg::CPU_ADDR;
            end
         end
         dram_glue_pkg::CPU_ADDR: begin
            state_next = dram_glue_pkg::CPU_DATA;
         end
         dram_glue_pkg::CPU_DATA: begin
            data_next = bus.data_to_cpu;
            fetch_done = 1'b1;
            count_next = 4'(dram_glue_pkg::PRECHARGE_GAP_CYCLES);
            state_next = dram_glue_pkg::CPU_GAP;
         end
         dram_glue_pkg::CPU_GAP: begin
            count_next = count_reg - 1'b1;
            if (count_reg == 4'h1) begin
               count_next = 4'(dram_glue_pkg::REFRESH_STROBE_CYCLES);
               state_next = dram_glue_pkg::CPU_REFRESH;
            end
         end
         dram_glue_pkg::CPU_REFRESH: begin
            count_next = count_reg - 1'b1;
            if (count_reg == 4'h1) begin
               refresh_row_next = refresh_row_reg + 1'b1;
               state_next = dram_glue_pkg::CPU_IDLE;
            end
         end
         dram_glue_pkg::CPU_HALT: begin
            if (!stall && !bus.cpu_reset) begin
               state_next = dram_glue_pkg::CPU_IDLE;
            end
         end
         default: state_next = dram_glue_pkg::CPU_IDLE;
      endcase
   end

   always_comb begin
      bus.mem_cycle_strobe_n = !(state_reg == dram_glue_pkg::CPU_ADDR ||
         state_reg == dram_glue_pkg::CPU_DATA ||
         state_reg == dram_glue_pkg::CPU_REFRESH);
      bus.refresh_cycle_flag_n = !(state_reg == dram_glue_pkg::CPU_GAP ||
         state_reg == dram_glue_pkg::CPU_REFRESH);
      bus.opcode_fetch_cycle_n = !(state_reg == dram_glue_pkg::CPU_ADDR ||
         state_reg == dram_glue_pkg::CPU_DATA);
      bus.read_strobe_n = bus.opcode_fetch_cycle_n;
      bus.write_strobe_n = 1'b1;
      bus.data_from_cpu = 8'h00;
      // Refresh row on low seven bits
      bus.address = bus.refresh_cycle_flag_n ? addr_reg :
         {9'h000, refresh_row_reg};
   end

   assign fetch_data = data_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= dram_glue_pkg::CPU_IDLE;
         count_reg <= 4'h0;
         refresh_row_reg <= 7'h00;
         addr_reg <= 16'h0000;
         data_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         refresh_row_reg <= refresh_row_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
      end
   end
endmodule // cpu_bus_end

// >>> cpu_dram_refresh_interface_props.sv
`timescale 1ns/10ps
module cpu_dram_refresh_interface_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] address,
   input wire logic mem_cycle_strobe_n,
   input wire logic refresh_cycle_flag_n,
   input wire logic opcode_fetch_cycle_n,
   input wire logic read_strobe_n,
   input wire logic data_to_cpu_oe,
   input wire logic cpu_reset,
   input wire logic [3:0] bank_base,
   input wire logic [3:0] row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic row_col_select
);
   logic hit;
   logic [7:0] since_fetch_reg;
   logic [7:0] since_fetch_next;
   logic [9:0] high_reg;
   logic [9:0] high_next;
   assign hit = address[15:14] == bank_base[3:2];
   // Saturate, so a long idle never wraps back to a small count
   always_comb begin
      since_fetch_next = since_fetch_reg;
      high_next = 10'h000;
      if (since_fetch_reg != 8'hFF) begin
         since_fetch_next = since_fetch_reg + 8'h01;
      end
      if (!opcode_fetch_cycle_n) begin
         since_fetch_next = 8'h00;
      end
      if (cpu_reset) begin
         high_next = (high_reg == 10'h3FF) ? high_reg : high_reg + 10'h001;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         since_fetch_reg <= 8'hFF;
         high_reg <= 10'h000;
      end else begin
         since_fetch_reg <= since_fetch_next;
         high_reg <= high_next;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ras_idle: assert property (
      mem_cycle_strobe_n |-> row_strobe_n == 4'hF) else $error("ras idle");
   a_ras_refresh_all: assert property (
      !mem_cycle_strobe_n && !refresh_cycle_flag_n |-> row_strobe_n == 4'h0)
      else $error("refresh ras");
   a_ras_decode_hit: assert property (
      $fell(mem_cycle_strobe_n) && refresh_cycle_flag_n |-> row_strobe_n ==
      (hit ? ~(4'h1 << address[13:12]) : 4'hF)) else $error("ras decode");
   a_ras_glitch_free: assert property (
      !mem_cycle_strobe_n && !$past(mem_cycle_strobe_n) |->
      $stable(row_strobe_n)) else $error("ras glitch");
   a_oe_qualified: assert property (
      data_to_cpu_oe |-> !mem_cycle_strobe_n && !read_strobe_n &&
      refresh_cycle_flag_n) else $error("oe qualify");
   a_oe_with_ras: assert property (
      $fell(mem_cycle_strobe_n) && !read_strobe_n && refresh_cycle_flag_n &&
      hit |-> data_to_cpu_oe) else $error("oe late");
   a_mux_next_edge: assert property (
      $fell(mem_cycle_strobe_n) && refresh_cycle_flag_n |->
      !row_col_select ##1 row_col_select) else $error("mux edge");
   a_cas_after_mux: assert property (
      !column_strobe_n |-> row_col_select && !mem_cycle_strobe_n)
      else $error("cas early");
   a_reset_at_fetch: assert property (
      $rose(cpu_reset) |-> since_fetch_reg <= 8'h08) else $error("rst sync");
   a_reset_short: assert property (
      cpu_reset |-> high_reg <= 10'h195) else $error("rst long");
   a_refresh_per_fetch: assert property (
      $rose(opcode_fetch_cycle_n) |->
      ##[1:8] ($fell(mem_cycle_strobe_n) && !refresh_cycle_flag_n))
      else $error("no refresh");
   a_gap_before_refresh: assert property (
      $rose(mem_cycle_strobe_n) && !refresh_cycle_flag_n |->
      mem_cycle_strobe_n [*4]) else $error("gap short");
   a_refresh_width: assert property (
      $fell(mem_cycle_strobe_n) && !refresh_cycle_flag_n |->
      (!mem_cycle_strobe_n) [*8]) else $error("refresh short");
   a_refresh_row_low: assert property (
      !refresh_cycle_flag_n |-> address[15:7] == 9'h000)
      else $error("refresh row");
   cover property ($fell(mem_cycle_strobe_n) && !refresh_cycle_flag_n);
   cover property (data_to_cpu_oe);
   cover property ($rose(cpu_reset));
endmodule // cpu_dram_refresh_interface_props

// >>> cpu_dram_refresh_interface_tb.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("mismatch at %0t: got %0h expected %0h", \
   $time, (got), (exp)); end end
module cpu_dram_refresh_interface_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic manual_reset_n = 1'b1;
   logic [3:0] bank_base = 4'h0;
   logic [7:0] mem_read_data = 8'h00;
   logic fetch_req = 1'b0;
   logic [15:0] fetch_address = 16'h0000;
   logic stall = 1'b0;
   logic [3:0] row_strobe_n;
   logic column_strobe_n;
   logic row_col_select;
   logic [6:0] mem_address;
   logic fetch_done;
   logic [7:0] fetch_data;
   logic ok_bit;
   int n_mismatch = 0;
   int tests_run = 0;
   int cnt;
   always #25 clk = ~clk;
   dram_bus_if bus ();
   dram_interface dram_interface_i (.clk(clk), .reset(reset), .bus(bus),
      .manual_reset_n(manual_reset_n), .bank_base(bank_base),
      .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
      .row_col_select(row_col_select), .mem_address(mem_address),
      .mem_write_n(), .mem_write_data(), .mem_read_data(mem_read_data));
   cpu_bus_end cpu_bus_end_i (.clk(clk), .reset(reset), .bus(bus),
      .fetch_req(fetch_req), .fetch_address(fetch_address), .stall(stall),
      .fetch_done(fetch_done), .fetch_data(fetch_data));
   cpu_dram_refresh_interface_props cpu_dram_refresh_interface_props_i (
      .clk(clk), .reset(reset), .address(bus.address),
      .mem_cycle_strobe_n(bus.mem_cycle_strobe_n),
      .refresh_cycle_flag_n(bus.refresh_cycle_flag_n),
      .opcode_fetch_cycle_n(bus.opcode_fetch_cycle_n),
      .read_strobe_n(bus.read_strobe_n), .data_to_cpu_oe(bus.data_to_cpu_oe),
      .cpu_reset(bus.cpu_reset), .bank_base(bank_base),
      .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
      .row_col_select(row_col_select));
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Counts edges until cpu_reset leaves the given level
   task automatic count_reset(input logic lvl);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > 1000) begin
            n_mismatch++;
            end_of_test;
         end
      end while (bus.cpu_reset === lvl);
   endtask
   task automatic fetch(input logic [3:0] b, input logic [15:0] a,
                        input logic [7:0] d);
      logic [3:0] rs;
      logic [3:0] exp_rs;
      logic [6:0] ma;
      logic cs;
      logic sel;
      exp_rs = 4'hF;
      if (a[15:14] == b[3:2]) exp_rs[a[13:12]] = 1'b0;
      bank_base <= b;
      mem_read_data <= d;
      fetch_address <= a;
      fetch_req <= 1'b1;
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > 40) begin
            n_mismatch++;
            end_of_test;
         end
      end while (fetch_done !== 1'b1);
      rs = row_strobe_n;
      ma = mem_address;
      cs = column_strobe_n;
      sel = row_col_select;
      @(posedge clk);
      fetch_req <= 1'b0;
      #1;
      `CHECK(rs, exp_rs)
      `CHECK(sel, 1'b1)
      `CHECK(cs, exp_rs == 4'hF)
      `CHECK(ma, {1'b0, a[11:6]})
      if (exp_rs != 4'hF) `CHECK(fetch_data, d)
      @(posedge clk);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      count_reset(1'b1);
      ok_bit = cnt >= dram_glue_pkg::POWER_ON_CYCLES - 2 &&
               cnt <= dram_glue_pkg::POWER_ON_CYCLES + 2;
      `CHECK(ok_bit, 1'b1)
      $display("test power_on done");
      @(posedge clk);
      for (int b = 0; b < 4; b++) begin
         for (int w = 0; w < 16; w++) begin
            fetch({b[1:0], 2'b00}, {w[3:0], 12'hA5C}, {b[1:0], 2'h2, w[3:0]});
         end
      end
      $display("test decode done");
      // Stall stays far below the refresh loss limit
      stall <= 1'b1;
      fetch_req <= 1'b1;
      repeat (20) begin
         @(posedge clk);
         #1;
         `CHECK(fetch_done, 1'b0)
      end
      @(posedge clk);
      stall <= 1'b0;
      fetch(4'h4, 16'h5123, 8'h96);
      $display("test stall done");
      manual_reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      manual_reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      `CHECK(bus.cpu_reset, 1'b0)
      @(posedge clk);
      fetch_req <= 1'b1;
      count_reset(1'b0);
      @(posedge clk);
      fetch_req <= 1'b0;
      count_reset(1'b1);
      ok_bit = cnt >= dram_glue_pkg::RESET_PULSE_CYCLES - 3 &&
               cnt <= dram_glue_pkg::RESET_PULSE_CYCLES + 1;
      `CHECK(ok_bit, 1'b1)
      @(posedge clk);
      fetch(4'h8, 16'hB7FF, 8'hE1);
      $display("test manual_reset done");
      end_of_test;
   end
endmodule // cpu_dram_refresh_interface_tb

// >>> dram_bus_if.sv
`timescale 1ns/10ps
interface dram_bus_if;
   logic [15:0] address;
   logic [7:0] data_from_cpu;
   logic [7:0] data_to_cpu;
   logic data_to_cpu_oe;
   logic mem_cycle_strobe_n;
   logic refresh_cycle_flag_n;
   logic opcode_fetch_cycle_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic cpu_reset;

   modport device (
      input address, data_from_cpu, mem_cycle_strobe_n,
      input refresh_cycle_flag_n, opcode_fetch_cycle_n,
      input read_strobe_n, write_strobe_n,
      output data_to_cpu, data_to_cpu_oe, cpu_reset
   );
   modport cpu (
      output address, data_from_cpu, mem_cycle_strobe_n,
      output refresh_cycle_flag_n, opcode_fetch_cycle_n,
      output read_strobe_n, write_strobe_n,
      input data_to_cpu, data_to_cpu_oe, cpu_reset
   );
endinterface // dram_bus_if

// >>> dram_glue_pkg.sv
package dram_glue_pkg;
   // Clock rate and timing figures
   localparam int CLK_PERIOD_NS = 50;
   localparam int PRECHARGE_GAP_NS = 160;
   localparam int PRECHARGE_GAP_CYCLES =
      (PRECHARGE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFRESH_STROBE_WIDTH_NS = 360;
   localparam int REFRESH_STROBE_CYCLES =
      (REFRESH_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS = 10000;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;
   localparam int POWER_ON_NS = 20000;
   localparam int POWER_ON_CYCLES = POWER_ON_NS / CLK_PERIOD_NS;
   // Address layout
   localparam int ADDR_WIDTH = 16;
   localparam int DATA_WIDTH = 8;
   localparam int BANK_LSB = 12;
   localparam int BANK_WIDTH = 4;
   localparam int REFRESH_ROW_WIDTH = 7;
   localparam int ROW_STROBES = 4;
   localparam logic [3:0] BANK_BASE_RESET = 4'h0;
   // Fetch sequence of the processor end
   typedef enum logic [5:0] {
      CPU_IDLE = 6'h01,
      CPU_ADDR = 6'h02,
      CPU_DATA = 6'h04,
      CPU_GAP = 6'h08,
      CPU_REFRESH = 6'h10,
      CPU_HALT = 6'h20
   } cpu_state_type;
endpackage

// >>> dram_interface.sv
`timescale 1ns/10ps
// Overview of operation
// - CPU refreshes in T3-T4 of every fetch
// - CPU keeps strobe idle 160ns before refresh
// - CPU holds refresh strobe at least 360ns
// - Row strobe derived combinationally from memory strobe
// - CPU never stalls or resets over 1ms
// - CPU clock above minimum refresh rate
// - Latch address bits 12-15 while strobe active
// - Bank decoder fed from live bits in first strobe cycle, then latched bits
// - Manual reset starts at opcode fetch start
// - Short reset pulse, plus power-on reset
// - Row strobe: strobe and (refresh or hit)
// - Decode hits only inside assigned address range
// - Output buffer enabled together with row strobe
// - Request-to-data path within 450ns/640ns
// - Refresh row on low seven address bits
// - Buffer enabled on decode, strobe and read
// - Row/column select switches next edge after strobe
module dram_interface (
   input wire logic clk,
   input wire logic reset,
   dram_bus_if.device bus,
   input wire logic manual_reset_n,
   input wire logic [3:0] bank_base,
   output logic [3:0] row_strobe_n,
   output logic column_strobe_n,
   output logic row_col_select,
   output logic [6:0] mem_address,
   output logic mem_write_n,
   output logic [7:0] mem_write_data,
   input wire logic [7:0] mem_read_data
);
   localparam int RST_W = 16;

   logic [3:0] bank_latch_reg;
   logic [3:0] bank_latch_next;
   logic strobe_seen_reg;
   logic strobe_seen_next;
   logic select_reg;
   logic select_next;
   logic [3:0] bank_used;
   logic hit;
   logic row_active;
   logic [7:0] read_data_reg;
   logic [7:0] read_data_next;
   logic button_sync;
   logic fetch_sync;
   logic fetch_prev_reg;
   logic fetch_prev_next;
   logic arm_reg;
   logic arm_next;
   logic [RST_W-1:0] pulse_count_reg;
   logic [RST_W-1:0] pulse_count_next;
   logic [RST_W-1:0] power_count_reg;
   logic [RST_W-1:0] power_count_next;
   logic cpu_reset_reg;
   logic cpu_reset_next;

   ////////////////////////////////////////////////////////////////////////
   // Address latch and decode
   always_comb begin
      bank_latch_next = bank_latch_reg;
      strobe_seen_next = !bus.mem_cycle_strobe_n;
      // Follows the bus up to the first edge inside the strobe,
      // then frozen until the strobe ends
      if (!strobe_seen_reg) begin
         bank_latch_next = bus.address[15:12];
      end
   end

   // Address and strobe move on the same edge, so the first strobe
   // cycle decodes the live bits and later ones the frozen copy;
   // both agree at the switch, so no decode glitch
   assign bank_used = strobe_seen_reg ? bank_latch_reg
                                      : bus.address[15:12];
   // Each row strobe covers one 4K bank inside a 16K window
   assign hit = (bank_used[3:2] == bank_base[3:2]);
   assign row_active = !bus.mem_cycle_strobe_n &&
      (!bus.refresh_cycle_flag_n || hit);

   // No clock in this path: strobe width follows request width
   always_comb begin
      row_strobe_n = 4'hF;
      if (row_active) begin
         if (!bus.refresh_cycle_flag_n) begin
            row_strobe_n = 4'h0;
         end else begin
            row_strobe_n[bank_used[1:0]] = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Row/column multiplexing
   always_comb begin
      select_next = 1'b0;
      if (!bus.mem_cycle_strobe_n && bus.refresh_cycle_flag_n) begin
         select_next = 1'b1;
      end
   end

   assign row_col_select = select_reg;
   // Column strobe only after switch; inhibited during refresh
   assign column_strobe_n = !(select_reg && !bus.mem_cycle_strobe_n &&
      bus.refresh_cycle_flag_n && hit);
   assign mem_address = !bus.refresh_cycle_flag_n ? bus.address[6:0] :
      (select_reg ? {1'b0, bus.address[11:6]} :
       {1'b0, bus.address[5:0]});
   assign mem_write_n = bus.write_strobe_n;
   assign mem_write_data = bus.data_from_cpu;

   ////////////////////////////////////////////////////////////////////////
   // Read data return
   always_comb begin
      read_data_next = mem_read_data;
   end

   // Buffer opens with the row strobe on reads
   assign bus.data_to_cpu_oe = hit && !bus.mem_cycle_strobe_n &&
      !bus.read_strobe_n && bus.refresh_cycle_flag_n;
   // Registered at the full rate; one 50ns step fits the fetch budget
   assign bus.data_to_cpu = read_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // Reset generator
   sync3 button_sync_i (
      .clk(clk),
      .reset(reset),
      .async_in(!manual_reset_n),
      .sync_out(button_sync)
   );
   // Fetch marker comes from logic on this clock: no synchroniser,
   // which also keeps the pulse start close to the fetch start
   assign fetch_sync = !bus.opcode_fetch_cycle_n;

   always_comb begin
      fetch_prev_next = fetch_sync;
      arm_next = arm_reg;
      pulse_count_next = pulse_count_reg;
      power_count_next = power_count_reg;
      cpu_reset_next = 1'b0;
      // Start only at a fetch's first edge, never mid-cycle
      if (arm_reg && fetch_sync && !fetch_prev_reg &&
          pulse_count_reg == '0) begin
         arm_next = 1'b0;
         pulse_count_next = RST_W'(dram_glue_pkg::RESET_PULSE_CYCLES);
      end else if (pulse_count_reg != '0) begin
         pulse_count_next = pulse_count_reg - 1'b1;
      end
      // A press in the firing cycle re-arms rather than being lost
      if (button_sync) begin
         arm_next = 1'b1;
      end
      if (power_count_reg != '0) begin
         power_count_next = power_count_reg - 1'b1;
      end
      // Pulse far below 1ms keeps refresh alive
      if (pulse_count_reg != '0 || power_count_reg != '0) begin
         cpu_reset_next = 1'b1;
      end
   end

   assign bus.cpu_reset = cpu_reset_reg;

   ////////////////////////////////////////////////////////////////////////
   // State registers, one block per group
   always_ff @(posedge clk) begin
      if (reset) begin
         bank_latch_reg <= 4'h0;
         strobe_seen_reg <= 1'h0;
      end else begin
         bank_latch_reg <= bank_latch_next;
         strobe_seen_reg <= strobe_seen_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         select_reg <= 1'h0;
      end else begin
         select_reg <= select_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         read_data_reg <= 8'h00;
      end else begin
         read_data_reg <= read_data_next;
      end
   end

   // Power-on count loads in reset, so the pulse runs on after release
   always_ff @(posedge clk) begin
      if (reset) begin
         fetch_prev_reg <= 1'h0;
         arm_reg <= 1'h0;
         pulse_count_reg <= '0;
         power_count_reg <= RST_W'(dram_glue_pkg::POWER_ON_CYCLES);
         cpu_reset_reg <= 1'h1;
      end else begin
         fetch_prev_reg <= fetch_prev_next;
         arm_reg <= arm_next;
         pulse_count_reg <= pulse_count_next;
         power_count_reg <= power_count_next;
         cpu_reset_reg <= cpu_reset_next;
      end
   end
endmodule // dram_interface

// >>> sync3.sv
`timescale 1ns/10ps
module sync3 (
   input wire logic clk,
   input wire logic reset,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic out_reg;
   logic out_next;

   always_comb begin
      stage_next = {stage_reg[1:0], async_in};
      out_next = out_reg;
      // Change accepted when second and third stage agree
      if (stage_reg[1] == stage_reg[2]) begin
         out_next = stage_reg[2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stage_reg <= 3'h0;
         out_reg <= 1'h0;
      end else begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end

   assign sync_out = out_reg;
endmodule // sync3
